/* File: scp_consts.vh */
// Constants for the serial command port and instruction sequencer
// Operation
// - Busy pin high after host byte finished
// - MSB one: busy after last clock rise
// - MSB zero: busy after data returns high
// - Data falling edge halts current operation
// - Mode bit two zero selects busy output
// - Normal mode default; host mode build-only
// - Received byte selects entry vector to run
// - Each instruction takes two sample periods
// - Unconditional instructions execute when issued
// - Conditional executes only if condition true
// - Jump, load, move, increment, end, conditional
// - Increment acts on first general register only
// - Enabled trigger edge interrupts idle or running state
`ifndef SCP_CONSTS_VH
`define SCP_CONSTS_VH

// ------------------------------------------------------------
// Register map (byte addresses)
// ------------------------------------------------------------
`define SCP_ADDR_STATUS     8'h00
`define SCP_ADDR_PROG_ADDR  8'h04
`define SCP_ADDR_PROG_DATA  8'h08
`define SCP_ADDR_GEN_REGS   8'h0c
`define SCP_ADDR_SPECIAL    8'h10
`define SCP_ADDR_PAGE       8'h14

// ------------------------------------------------------------
// Reset values and fields
// ------------------------------------------------------------
`define SCP_MODE_CONFIG0_RST       8'h00
`define SCP_MODE_CONFIG0_PIN_SEL   2
`define SCP_POI_VECTOR      8'h20
`define SCP_RESP_OKAY       2'b00
`define SCP_RESP_SLVERR     2'b10

// ------------------------------------------------------------
// Instruction layout: op[17:14] cond[13:12] pin[11:10] rn[9:8] value[7:0]
// ------------------------------------------------------------
`define SCP_OP_END          4'h0
`define SCP_OP_JP_VEC       4'h1
`define SCP_OP_JP_REG       4'h2
`define SCP_OP_LD_EN0       4'h3
`define SCP_OP_LD_EN1       4'h4
`define SCP_OP_LD_MODE_CONFIG0     4'h5
`define SCP_OP_LD_MODE1     4'h6
`define SCP_OP_LD_STOP      4'h7
`define SCP_OP_LD_PAGE      4'h8
`define SCP_OP_LD_REG       4'h9
`define SCP_OP_MV           4'ha
`define SCP_OP_INC          4'hb
`define SCP_COND_NONE       2'h0
`define SCP_COND_LAST       2'h1
`define SCP_COND_HIGH       2'h2
`define SCP_COND_LOW        2'h3

// ------------------------------------------------------------
// Trigger vectors
// ------------------------------------------------------------
`define SCP_VEC_DATA_FALL   8'h00
`define SCP_VEC_CLK_FALL    8'h01
`define SCP_VEC_DATA_RISE   8'h04
`define SCP_VEC_CLK_RISE    8'h05
`define SCP_VEC_T5_FALL     8'h08
`define SCP_VEC_T6_FALL     8'h09
`define SCP_VEC_T5_RISE     8'h0c
`define SCP_VEC_T6_RISE     8'h0d

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define SCP_CLK_HZ          10000000
`define SCP_SAMPLE_RATE_HZ  6000
`define SCP_INSTR_PERIODS   2
`define SCP_INSTR_CYCLES    ((`SCP_INSTR_PERIODS * `SCP_CLK_HZ) / `SCP_SAMPLE_RATE_HZ)

`endif

/* File: scp_sync2.v */
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module scp_sync2 #(
  parameter W = 4
) (
  input  wire         aclk,
  input  wire         aresetn,
  input  wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);

  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;

  // Idle level of pulled-up pins is high
  always @(posedge aclk) begin
    if (!aresetn) begin
      meta_ff <= {W{1'b1}};
      sync_ff <= {W{1'b1}};
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule

/* File: scp_top.v */
// Serial command port, trigger edges and instruction sequencer with AXI4-Lite access
//
// The placing of the registers and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "scp_consts.vh"
module scp_top #(
  parameter HOST_CMD_MODE = 0
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        serial_data_pin,
  input  wire        serial_clock_pin,
  input  wire [1:0]  spare_trigger_pins,
  input  wire        play_last,
  output wire        stop_a_or_busy_pin,
  output wire [3:0]  stop_outputs_b_to_e,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready
);

  // ------------------------------------------------------------
  // States and timing
  // ------------------------------------------------------------
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_RUN  = 4'b0010;
  localparam [3:0] ST_RECV = 4'b0100;
  localparam [3:0] ST_WAIT = 4'b1000;
  localparam integer INSTR_CYC  = `SCP_INSTR_CYCLES;
  localparam [11:0]  INSTR_LAST = INSTR_CYC[11:0] - 12'd1;

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  wire [3:0]  pins_s;
  reg  [3:0]  pins_prev_ff;
  reg  [3:0]  state_ff, nxt_state;
  reg  [11:0] timer_ff, nxt_timer;
  reg  [7:0]  pc_ff, nxt_pc;
  reg  [7:0]  shift_ff, nxt_shift;
  reg  [2:0]  bitcnt_ff, nxt_bitcnt;
  reg  [7:0]  last_byte_ff, nxt_last_byte;
  reg         busy_ff, nxt_busy;
  reg  [7:0]  en0_ff, nxt_en0;
  reg  [7:0]  en1_ff, nxt_en1;
  reg  [7:0]  mode_config0_ff, nxt_mode_config0;
  reg  [7:0]  mode1_ff, nxt_mode1;
  reg  [7:0]  stop_ff, nxt_stop;
  reg  [7:0]  page_ff, nxt_page;
  reg  [31:0] gr_ff, nxt_gr;
  reg         pin_ff;
  reg  [17:0] prog_mem [0:255];
  reg  [7:0]  prog_addr_ff;
  reg         awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  reg  [1:0]  bresp_ff, rresp_ff;
  reg  [31:0] rdata_ff;
  reg  [7:0]  aw_addr_ff;
  reg  [31:0] w_data_ff;
  reg         aw_have_ff, w_have_ff;
  reg         cond_ok;
  reg         trig_hit;
  reg  [7:0]  trig_vec;
  wire [17:0] instr;
  wire [3:0]  fall;
  wire [3:0]  rise;
  wire [3:0]  op;
  wire [1:0]  cond;
  wire [1:0]  cpin;
  wire [1:0]  rn;
  wire [7:0]  val;
  wire        data_fall;
  wire        clk_rise;
  wire        data_rise;
  wire        wr_fire;
  wire        prog_wr;

  // ------------------------------------------------------------
  // Pin synchronisation and edge detection
  // ------------------------------------------------------------
  scp_sync2 #(.W(4)) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({spare_trigger_pins, serial_clock_pin, serial_data_pin}),
    .sync_out (pins_s)
  );

  // Previous synchronised pin levels
  always @(posedge aclk) begin
    if (!aresetn) begin
      pins_prev_ff <= 4'hf;
    end else begin
      pins_prev_ff <= pins_s;
    end
  end

  assign fall      = pins_prev_ff & ~pins_s;
  assign rise      = ~pins_prev_ff & pins_s;
  assign data_fall = fall[0];
  assign data_rise = rise[0];
  assign clk_rise  = rise[1];

  // Instruction fields
  assign instr = prog_mem[pc_ff];
  assign op    = instr[17:14];
  assign cond  = instr[13:12];
  assign cpin  = instr[11:10];
  assign rn    = instr[9:8];
  assign val   = instr[7:0];

  // Condition evaluation
  always @* begin
    case (cond)
      `SCP_COND_NONE: cond_ok = 1'b1;
      `SCP_COND_LAST: cond_ok = play_last;
      `SCP_COND_HIGH: cond_ok = pins_s[cpin];
      default:        cond_ok = ~pins_s[cpin];
    endcase
  end

  // Enabled trigger edges, lowest vector first
  always @* begin
    trig_hit = 1'b1;
    trig_vec = `SCP_VEC_DATA_FALL;
    if (en0_ff[0] && fall[0] && (HOST_CMD_MODE == 0)) begin
      trig_vec = `SCP_VEC_DATA_FALL;
    end else if (en0_ff[1] && fall[1]) begin
      trig_vec = `SCP_VEC_CLK_FALL;
    end else if (en0_ff[4] && rise[0]) begin
      trig_vec = `SCP_VEC_DATA_RISE;
    end else if (en0_ff[5] && rise[1]) begin
      trig_vec = `SCP_VEC_CLK_RISE;
    end else if (en1_ff[0] && fall[2]) begin
      trig_vec = `SCP_VEC_T5_FALL;
    end else if (en1_ff[1] && fall[3]) begin
      trig_vec = `SCP_VEC_T6_FALL;
    end else if (en1_ff[4] && rise[2]) begin
      trig_vec = `SCP_VEC_T5_RISE;
    end else if (en1_ff[5] && rise[3]) begin
      trig_vec = `SCP_VEC_T6_RISE;
    end else begin
      trig_hit = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Sequencer and serial receiver next state
  // ------------------------------------------------------------
  always @* begin
    nxt_state     = state_ff;
    nxt_timer     = timer_ff;
    nxt_pc        = pc_ff;
    nxt_shift     = shift_ff;
    nxt_bitcnt    = bitcnt_ff;
    nxt_last_byte = last_byte_ff;
    nxt_busy      = busy_ff;
    nxt_en0       = en0_ff;
    nxt_en1       = en1_ff;
    nxt_mode_config0     = mode_config0_ff;
    nxt_mode1     = mode1_ff;
    nxt_stop      = stop_ff;
    nxt_page      = page_ff;
    nxt_gr        = gr_ff;
    if ((HOST_CMD_MODE != 0) && data_fall && (state_ff == ST_IDLE || state_ff == ST_RUN)) begin
      nxt_state  = ST_RECV;
      nxt_busy   = 1'b0;
      nxt_bitcnt = 3'd0;
    end else if (trig_hit && (state_ff == ST_IDLE || state_ff == ST_RUN)) begin
      nxt_state = ST_RUN;
      nxt_pc    = trig_vec;
      nxt_timer = 12'd0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          nxt_timer = 12'd0;
        end
        ST_RUN: begin
          if (timer_ff == INSTR_LAST) begin
            nxt_timer = 12'd0;
            nxt_pc    = pc_ff + 8'd1;
            if (cond_ok) begin
              case (op)
                `SCP_OP_END: begin
                  nxt_state = ST_IDLE;
                  nxt_busy  = 1'b0;
                  nxt_pc    = pc_ff;
                end
                `SCP_OP_JP_VEC:   nxt_pc = val;
                `SCP_OP_JP_REG:   nxt_pc = gr_ff[rn*8 +: 8];
                `SCP_OP_LD_EN0:   nxt_en0 = val;
                `SCP_OP_LD_EN1:   nxt_en1 = val;
                `SCP_OP_LD_MODE_CONFIG0: nxt_mode_config0 = val;
                `SCP_OP_LD_MODE1: nxt_mode1 = val;
                `SCP_OP_LD_STOP:  nxt_stop = val;
                `SCP_OP_LD_PAGE:  nxt_page = val;
                `SCP_OP_LD_REG:   nxt_gr[rn*8 +: 8] = val;
                `SCP_OP_MV:       nxt_gr[rn*8 +: 8] = gr_ff[val[1:0]*8 +: 8];
                `SCP_OP_INC:      nxt_gr[7:0] = gr_ff[7:0] + 8'd1;
                default:          nxt_pc = pc_ff + 8'd1;
              endcase
            end
          end else begin
            nxt_timer = timer_ff + 12'd1;
          end
        end
        ST_RECV: begin
          if (clk_rise) begin
            nxt_shift  = {pins_s[0], shift_ff[7:1]};
            nxt_bitcnt = bitcnt_ff + 3'd1;
            if (bitcnt_ff == 3'd7) begin
              nxt_last_byte = {pins_s[0], shift_ff[7:1]};
              if (pins_s[0]) begin
                nxt_state = ST_RUN;
                nxt_busy  = 1'b1;
                nxt_pc    = {pins_s[0], shift_ff[7:1]};
                nxt_timer = 12'd0;
              end else begin
                nxt_state = ST_WAIT;
              end
            end
          end
        end
        ST_WAIT: begin
          if (data_rise) begin
            nxt_state = ST_RUN;
            nxt_busy  = 1'b1;
            nxt_pc    = last_byte_ff;
            nxt_timer = 12'd0;
          end
        end
        default: begin
          nxt_state = ST_IDLE;
        end
      endcase
    end
  end

  // Sequencer registers; power-on entry runs first
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_ff     <= ST_RUN;
      timer_ff     <= 12'd0;
      pc_ff        <= `SCP_POI_VECTOR;
      shift_ff     <= 8'h00;
      bitcnt_ff    <= 3'd0;
      last_byte_ff <= 8'h00;
      busy_ff      <= 1'b0;
      en0_ff       <= 8'h00;
      en1_ff       <= 8'h00;
      mode_config0_ff     <= `SCP_MODE_CONFIG0_RST;
      mode1_ff     <= 8'h00;
      stop_ff      <= 8'h00;
      page_ff      <= 8'h00;
      gr_ff        <= 32'h0000_0000;
      pin_ff       <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      timer_ff     <= nxt_timer;
      pc_ff        <= nxt_pc;
      shift_ff     <= nxt_shift;
      bitcnt_ff    <= nxt_bitcnt;
      last_byte_ff <= nxt_last_byte;
      busy_ff      <= nxt_busy;
      en0_ff       <= nxt_en0;
      en1_ff       <= nxt_en1;
      mode_config0_ff     <= nxt_mode_config0;
      mode1_ff     <= nxt_mode1;
      stop_ff      <= nxt_stop;
      page_ff      <= nxt_page;
      gr_ff        <= nxt_gr;
      pin_ff       <= nxt_mode_config0[`SCP_MODE_CONFIG0_PIN_SEL] ? nxt_stop[0] : nxt_busy;
    end
  end

  assign stop_a_or_busy_pin  = pin_ff;
  assign stop_outputs_b_to_e = stop_ff[4:1];

  // ------------------------------------------------------------
  // AXI4-Lite slave
  // ------------------------------------------------------------
  assign wr_fire = aw_have_ff && w_have_ff && !bvalid_ff;
  assign prog_wr = wr_fire && (aw_addr_ff == `SCP_ADDR_PROG_DATA);

  // Program memory write port
  always @(posedge aclk) begin
    if (prog_wr) begin
      prog_mem[prog_addr_ff] <= w_data_ff[17:0];
    end
  end

  // Write channels, taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff   <= 1'b1;
      wready_ff    <= 1'b1;
      aw_have_ff   <= 1'b0;
      w_have_ff    <= 1'b0;
      aw_addr_ff   <= 8'h00;
      w_data_ff    <= 32'h0000_0000;
      bvalid_ff    <= 1'b0;
      bresp_ff     <= `SCP_RESP_OKAY;
      prog_addr_ff <= 8'h00;
    end else begin
      if (s_axi_awvalid && awready_ff) begin
        aw_addr_ff <= s_axi_awaddr;
        aw_have_ff <= 1'b1;
        awready_ff <= 1'b0;
      end
      if (s_axi_wvalid && wready_ff) begin
        w_data_ff <= s_axi_wdata;
        w_have_ff <= 1'b1;
        wready_ff <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= `SCP_RESP_OKAY;
        if (aw_addr_ff == `SCP_ADDR_PROG_ADDR) begin
          prog_addr_ff <= w_data_ff[7:0];
        end else if (aw_addr_ff == `SCP_ADDR_PROG_DATA) begin
          prog_addr_ff <= prog_addr_ff + 8'd1;
        end else begin
          bresp_ff <= `SCP_RESP_SLVERR;
        end
      end
      if (bvalid_ff && s_axi_bready) begin
        bvalid_ff  <= 1'b0;
        aw_have_ff <= 1'b0;
        w_have_ff  <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff  <= 1'b1;
      end
    end
  end

  // Read channel, one cycle to data
  always @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= `SCP_RESP_OKAY;
    end else if (s_axi_arvalid && arready_ff) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b1;
      rresp_ff   <= `SCP_RESP_OKAY;
      case (s_axi_araddr)
        `SCP_ADDR_STATUS:    rdata_ff <= {last_byte_ff, pc_ff, 11'h000, busy_ff, state_ff};
        `SCP_ADDR_PROG_ADDR: rdata_ff <= {24'h000000, prog_addr_ff};
        `SCP_ADDR_PROG_DATA: rdata_ff <= {14'h0000, prog_mem[prog_addr_ff]};
        `SCP_ADDR_GEN_REGS:  rdata_ff <= gr_ff;
        `SCP_ADDR_SPECIAL:   rdata_ff <= {stop_ff, mode1_ff, mode_config0_ff, en0_ff};
        `SCP_ADDR_PAGE:      rdata_ff <= {16'h0000, en1_ff, page_ff};
        default: begin
          rdata_ff <= 32'h0000_0000;
          rresp_ff <= `SCP_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff  <= 1'b0;
      arready_ff <= 1'b1;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

endmodule

/* File: scp_top_chk.sv */
// Assertion checker bound to the serial command port top
`timescale 1ns/1ps
`include "scp_consts.vh"
module scp_top_chk #(
  parameter HOST_CMD_MODE = 0
) (
  input wire        aclk,
  input wire        aresetn,
  input wire        serial_data_pin,
  input wire        serial_clock_pin,
  input wire        stop_a_or_busy_pin,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------------------------
  // Link clock rises counted per frame, cleared once data idles
  // ----------------------------------------------------------
  logic       clk_q_ff;
  logic       dat_q_ff;
  logic [3:0] rises_ff;
  always_ff @(posedge aclk) begin
    clk_q_ff <= serial_clock_pin;
    dat_q_ff <= serial_data_pin;
    if (!aresetn || (rises_ff == 4'h8 && dat_q_ff)) begin
      rises_ff <= 4'h0;
    end else if (serial_clock_pin && !clk_q_ff) begin
      rises_ff <= rises_ff + 4'h1;
    end
  end
  sequence s_both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_frame_done;
    HOST_CMD_MODE != 0 && rises_ff == 4'h8 && dat_q_ff;
  endsequence
  property p_wr_answer;
    s_both_taken |=> !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid;
  endproperty
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_rd_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
  endproperty
  property p_r_err;
    s_axi_rvalid && s_axi_rresp == `SCP_RESP_SLVERR |-> s_axi_rdata == 32'h0;
  endproperty
  property p_busy_frame;
    s_frame_done |-> ##[1:8] stop_a_or_busy_pin;
  endproperty
  property p_busy_rise;
    HOST_CMD_MODE != 0 && $rose(stop_a_or_busy_pin) |-> $past(serial_data_pin, 2) && $past(serial_clock_pin, 2);
  endproperty
  property p_halt;
    HOST_CMD_MODE != 0 && $fell(serial_data_pin) && stop_a_or_busy_pin |-> ##[1:8] !stop_a_or_busy_pin;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write response missing");
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  a_rd_answer: assert property (p_rd_answer) else $error("read response missing");
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  a_r_err: assert property (p_r_err) else $error("refused read carries data");
  a_busy_frame: assert property (p_busy_frame) else $error("busy late after byte");
  a_busy_rise: assert property (p_busy_rise) else $error("busy rose mid frame");
  a_halt: assert property (p_halt) else $error("data fall did not halt");
endmodule
bind scp_top scp_top_chk #(.HOST_CMD_MODE(HOST_CMD_MODE)) i_scp_top_chk (
  .aclk, .aresetn, .serial_data_pin, .serial_clock_pin, .stop_a_or_busy_pin, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

/* File: scp_host_model.sv */
// Host controller model driving the two-wire command link
`timescale 1ns/1ps
module scp_host_model (
  input  wire aclk,
  output reg  serial_data_pin,
  output reg  serial_clock_pin
);
  // Both lines idle high; clock stands still outside frames
  initial begin
    serial_data_pin  = 1'b1;
    serial_clock_pin = 1'b1;
  end
  // Frame start: data falls while clock is high
  task start_frame;
    begin
      @(posedge aclk);
      serial_data_pin <= 1'b0;
      repeat (4) @(posedge aclk);
    end
  endtask
  // Eight bits LSB first, data changed mid low phase, 800 ns period
  task send_bits(input [7:0] b);
    integer i;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        serial_clock_pin <= 1'b0;
        repeat (2) @(posedge aclk);
        serial_data_pin <= b[i];
        repeat (2) @(posedge aclk);
        serial_clock_pin <= 1'b1;
        repeat (4) @(posedge aclk);
      end
    end
  endtask
  // Data back to idle high after the byte
  task release_line;
    begin
      serial_data_pin <= 1'b1;
      @(posedge aclk);
    end
  endtask
endmodule

/* File: test_speech_cpu_serial_command_port.sv */
// Self-checking bench for the serial command port in host-command mode
`timescale 1ns/1ps
`include "scp_consts.vh"
module test_speech_cpu_serial_command_port;
  reg         aclk;
  reg         aresetn;
  reg         play_last;
  reg  [1:0]  spare_trigger_pins;
  reg         s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  reg  [7:0]  s_axi_awaddr, s_axi_araddr;
  reg  [31:0] s_axi_wdata, rd, r0_before;
  reg  [1:0]  resp;
  wire        serial_data_pin, serial_clock_pin, stop_a_or_busy_pin;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [3:0]  stop_outputs_b_to_e;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  integer     miscompares = 0;
  integer     compares = 0;
  integer     cycles = 0;
  localparam [31:0] I_END = {14'h0, `SCP_OP_END, 14'h0};
  scp_top #(.HOST_CMD_MODE(1)) i_scp_top (
    .aclk, .aresetn, .serial_data_pin, .serial_clock_pin, .spare_trigger_pins, .play_last,
    .stop_a_or_busy_pin, .stop_outputs_b_to_e, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  scp_host_model i_scp_host_model (.aclk, .serial_data_pin, .serial_clock_pin);
  // ----------------------------------------------------------
  // Clock, hang guard and shared tasks
  // ----------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cycles = cycles + 1;
    if (cycles == 60000) begin
      miscompares = miscompares + 1;
      final_report;
    end
  end
  task final_report;
    begin
      $display("compares=%0d miscompares=%0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  task chk(input ok, input string msg);
    begin
      compares = compares + 1;
      if (ok !== 1'b1) begin
        miscompares = miscompares + 1;
        $display("CHECK FAILED at %0t: %0s", $time, msg);
      end
    end
  endtask
  // Write: address and data offered together, each dropped when taken
  task axi_wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
        @(posedge aclk);
        if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        resp = s_axi_bresp;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
    end
  endtask
  task axi_rd(input [7:0] a);
    begin
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
        @(posedge aclk);
        if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        rd   = s_axi_rdata;
        resp = s_axi_rresp;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
    end
  endtask
  function [31:0] ins(input [3:0] op, input [1:0] cond, input [7:0] v);
    ins = {14'h0, op, cond, 4'h0, v};
  endfunction
  // Four instructions from an entry vector, auto-incremented address
  task load(input [7:0] vec, input [31:0] i0, input [31:0] i1, input [31:0] i2, input [31:0] i3);
    begin
      axi_wr(`SCP_ADDR_PROG_ADDR, {24'h0, vec});
      axi_wr(`SCP_ADDR_PROG_DATA, i0);
      axi_wr(`SCP_ADDR_PROG_DATA, i1);
      axi_wr(`SCP_ADDR_PROG_DATA, i2);
      axi_wr(`SCP_ADDR_PROG_DATA, i3);
    end
  endtask
  task wait_pin(input v, input integer max, output integer n);
    begin
      n = 0;
      while (stop_a_or_busy_pin !== v && n < max) begin
        @(posedge aclk);
        n = n + 1;
      end
    end
  endtask
  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  task t_reset_bus;
    begin
      chk(stop_a_or_busy_pin === 1'b0 && stop_outputs_b_to_e === 4'h0, "reset outputs");
      axi_rd(`SCP_ADDR_STATUS);
      chk(rd[3:0] === 4'h2 && rd[23:16] === `SCP_POI_VECTOR, "power-on entry");
      axi_wr(`SCP_ADDR_STATUS, 32'h1);
      chk(resp === `SCP_RESP_SLVERR, "read-only write accepted");
      axi_rd(8'h18);
      chk(resp === `SCP_RESP_SLVERR && rd === 32'h0, "unmapped read");
    end
  endtask
  task t_msb_one;
    integer n;
    begin
      i_scp_host_model.start_frame;
      i_scp_host_model.send_bits(8'hc1);
      wait_pin(1'b1, 12, n);
      chk(stop_a_or_busy_pin === 1'b1, "no busy after last rise");
      repeat (3000) @(posedge aclk);
      chk(stop_outputs_b_to_e === 4'h0, "instruction ran early");
      repeat (500) @(posedge aclk);
      chk(stop_outputs_b_to_e === 4'hf, "received vector not run");
      wait_pin(1'b0, 3500, n);
      chk(stop_a_or_busy_pin === 1'b0 && n > 2900, "end timing");
    end
  endtask
  task t_msb_zero_halt;
    integer n;
    begin
      axi_rd(`SCP_ADDR_GEN_REGS);
      r0_before = rd;
      i_scp_host_model.start_frame;
      i_scp_host_model.send_bits(8'h41);
      repeat (20) @(posedge aclk);
      chk(stop_a_or_busy_pin === 1'b0, "busy while data low");
      i_scp_host_model.release_line;
      wait_pin(1'b1, 12, n);
      chk(stop_a_or_busy_pin === 1'b1, "no busy after data high");
      repeat (100) @(posedge aclk);
      i_scp_host_model.start_frame;
      repeat (4) @(posedge aclk);
      chk(stop_a_or_busy_pin === 1'b0, "no halt on data fall");
      i_scp_host_model.send_bits(8'h90);
      wait_pin(1'b1, 12, n);
      wait_pin(1'b0, 14000, n);
      chk(stop_outputs_b_to_e === 4'h1, "conditional load");
      axi_rd(`SCP_ADDR_GEN_REGS);
      chk(rd === r0_before + 32'h1, "increment count");
    end
  endtask
  // Byte 0xa0 enables the spare fall edge; the fall runs vector 8
  task t_spare_trigger;
    integer n;
    begin
      i_scp_host_model.start_frame;
      i_scp_host_model.send_bits(8'ha0);
      wait_pin(1'b1, 12, n);
      wait_pin(1'b0, 7000, n);
      spare_trigger_pins <= 2'b10;
      repeat (3400) @(posedge aclk);
      chk(stop_outputs_b_to_e === 4'h2, "spare fall vector or low condition");
    end
  endtask
  // Main sequence; programs leave both serial pin edge enables cleared
  initial begin
    aresetn       = 1'b0;
    play_last     = 1'b0;
    spare_trigger_pins = 2'b11;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid  = 1'b0;
    s_axi_bready  = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready  = 1'b0;
    s_axi_awaddr  = 8'h00;
    s_axi_araddr  = 8'h00;
    s_axi_wdata   = 32'h0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset_bus;
    load(8'h20, I_END, I_END, I_END, I_END);
    load(8'hff, I_END, I_END, I_END, I_END);
    load(8'hc1, ins(`SCP_OP_LD_STOP, `SCP_COND_NONE, 8'h1e), I_END, I_END, I_END);
    load(8'h41, ins(`SCP_OP_INC, `SCP_COND_NONE, 8'h00), I_END, I_END, I_END);
    load(8'h90, ins(`SCP_OP_INC, `SCP_COND_LAST, 8'h00), ins(`SCP_OP_LD_STOP, `SCP_COND_HIGH, 8'h02),
         ins(`SCP_OP_INC, `SCP_COND_NONE, 8'h00), I_END);
    axi_rd(`SCP_ADDR_PROG_ADDR);
    chk(rd[7:0] === 8'h94, "program address increment");
    load(8'ha0, ins(`SCP_OP_LD_EN1, `SCP_COND_NONE, 8'h01), I_END, I_END, I_END);
    load(8'h08, ins(`SCP_OP_LD_STOP, `SCP_COND_LOW, 8'h04) | 32'h800, I_END, I_END, I_END);
    t_msb_one;
    t_msb_zero_halt;
    t_spare_trigger;
    final_report;
  end
endmodule
